/* File: rtl/irq_wakeup_pkg.sv */
// package: register map, field positions, reset values and timing counts
// assumes a 32-bit classic wishbone slave on a 100 MHz clock
package irq_wakeup_pkg;

  // =====================================================
  // geometry
  localparam int NUM_TM = 3;
  localparam int ADDR_W = 8;
  localparam int SRC_W = 2 * NUM_TM + 2;

  // =====================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_SUPPLY_MONITOR_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TM_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TM_ENABLES = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

  // =====================================================
  // supply monitor control fields
  localparam int SUPPLY_SEL_LSB = 0;
  localparam int SUPPLY_SEL_W = 3;
  localparam int SUPPLY_ON_BIT = 4;
  localparam int SUPPLY_LOW_BIT = 5;
  localparam logic [7:0] SUPPLY_CTRL_WMASK = 8'h17;

  // tm flag / enable layout: per module i, bit 4i period, 4i+1 compare a, 4i+2 compare b
  localparam int TM_STRIDE = 4;
  localparam int TM_P_BIT = 0;
  localparam int TM_A_BIT = 1;
  localparam int TM_B_BIT = 2;
  localparam int ENHANCED_TM = 2;
  // bit 12 of flags register holds the supply-low irq flag, enables bit 12 its enable
  localparam int SUPPLY_IRQ_BIT = 12;

  // core control fields
  localparam int GLOBAL_EN_BIT = 0;
  localparam int GROUP_EN_BIT = 1;
  localparam int GROUP_FLAG_BIT = 2;
  localparam int STACK_FULL_BIT = 3;
  localparam int SLEEP_BIT = 4;

  // status / mask bits
  localparam int EV_TM_BIT = 0;
  localparam int EV_SUPPLY_BIT = 1;
  localparam int EV_WAKE_BIT = 2;
  localparam int EV_VECTOR_BIT = 3;
  localparam int EV_W = 4;

  // =====================================================
  // reset values
  localparam logic [7:0] SUPPLY_CTRL_RST = 8'h00;
  localparam logic [12:0] FLAGS_RST = 13'h0000;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // =====================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SUPPLY_IRQ_DELAY_US = 15;
  localparam int SUPPLY_IRQ_DELAY_CYC = SUPPLY_IRQ_DELAY_US * CLK_MHZ;
  localparam int DLY_W = 12;

  // =====================================================
  // core handshake state
  typedef enum logic [2:0] {
    CORE_RUN = 3'b001,
    CORE_VECTOR = 3'b010,
    CORE_SERVICE = 3'b100
  } core_state_e;

endpackage : irq_wakeup_pkg

/* File: rtl/flag_edge_latch.sv */
// sticky request flag with software write and set-wins-over-clear
// assumes set pulse and writes come from clk_i logic
`timescale 1ns/1ps
module flag_edge_latch (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // hardware set and software access
  input wire logic set_i,
  input wire logic hw_clear_i,
  input wire logic sw_we_i,
  input wire logic sw_val_i,
  // flag and its rising edge
  output logic flag_o,
  output logic rise_o
);

  typedef struct packed {
    logic flag;
    logic rise;
  } st_s;

  st_s st;
  st_s next_st;

  always_comb begin
    next_st = st;
    if (sw_we_i || hw_clear_i) begin
      next_st.flag = sw_we_i ? sw_val_i : 1'b0;
    end
    if (set_i) begin
      next_st.flag = 1'b1;
    end
    next_st.rise = next_st.flag & ~st.flag;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag_o = st.flag;
  assign rise_o = st.rise;

endmodule : flag_edge_latch

/* File: rtl/irq_wakeup_supply_monitor.sv */
// interrupt request, service and wake-up logic for timer and supply sources
// assumes timer match strobes and core strobes on clk_i, comparator from a pin
//
// Summary of operation
// - two timer flags/enables, third on enhanced
// - comparator match sets timer request flag
// - vector only when all enables, pending, stack free
// - entry clears global enable and group flag
// - any flag rise wakes, enables ignored
// - flags hold until cleared by a software write; entry does not clear them
// - entry pushes only program counter
// - irq return sets global enable, plain not
// - three-bit threshold selects eight levels
// - supply-low flag reads comparator state
// - detector enable turns detector on
// - unimplemented control bits read zero
// - supply irq after fixed settling delay
// - detector works in sleep, wakes device
// - supply-low flag follows comparator unfiltered
`timescale 1ns/1ps
module irq_wakeup_supply_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [irq_wakeup_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // timer comparator match strobes
  input wire logic [irq_wakeup_pkg::NUM_TM-1:0] tm_period_match_i,
  input wire logic [irq_wakeup_pkg::NUM_TM-1:0] tm_compare_a_i,
  input wire logic [irq_wakeup_pkg::NUM_TM-1:0] tm_compare_b_i,
  // supply comparator
  input wire logic supply_below_i,
  output logic supply_monitor_on_o,
  output logic [irq_wakeup_pkg::SUPPLY_SEL_W-1:0] supply_threshold_sel_o,
  // processor core
  input wire logic stack_full_i,
  input wire logic vector_ack_i,
  input wire logic [11:0] pc_i,
  input wire logic return_from_irq_i,
  input wire logic return_plain_i,
  output logic vector_req_o,
  output logic push_pc_o,
  output logic [11:0] push_pc_data_o,
  output logic global_irq_enable_o,
  // wake-up and interrupt
  output logic wake_o,
  output logic irq_o
);
  import irq_wakeup_pkg::*;

  // =====================================================
  // state
  typedef struct packed {
    core_state_e core;
    logic [7:0] supply_ctrl;
    logic [12:0] enables;
    logic global_en;
    logic group_en;
    logic group_flag;
    logic sleep;
    logic [DLY_W-1:0] dly;
    logic dly_run;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [1:0] cmp_sync;
    logic ack;
    logic [31:0] rdata;
    logic vreq;
    logic push;
    logic [11:0] push_data;
    logic wake;
    logic irq;
  } st_s;

  st_s st;
  st_s next_st;

  function automatic logic hit(input logic [ADDR_W-1:0] ofs);
    hit = cyc_i && stb_i && we_i && !st.ack && (adr_i == ofs) && sel_i[0];
  endfunction : hit

  function automatic logic implemented(input int b);
    implemented = (b % TM_STRIDE != TM_B_BIT) || (b / TM_STRIDE == ENHANCED_TM);
  endfunction : implemented

  // =====================================================
  // request flags
  logic [12:0] set_vec;
  logic [12:0] flags;
  logic [12:0] rises;
  logic [12:0] fl_we;
  logic [15:0] wr16;
  logic dly_done;

  always_comb begin
    set_vec = '0;
    for (int i = 0; i < NUM_TM; i++) begin
      set_vec[i*TM_STRIDE+TM_P_BIT] = tm_period_match_i[i];
      set_vec[i*TM_STRIDE+TM_A_BIT] = tm_compare_a_i[i];
      set_vec[i*TM_STRIDE+TM_B_BIT] = tm_compare_b_i[i] && (i == ENHANCED_TM);
    end
    set_vec[SUPPLY_IRQ_BIT] = dly_done;
  end

  assign wr16 = {(sel_i[1] ? dat_i[15:8] : 8'h00), dat_i[7:0]};
  assign fl_we = (cyc_i && stb_i && we_i && !st.ack && adr_i == OFS_TM_FLAGS)
               ? {sel_i[1], {4{sel_i[1]}}, {8{sel_i[0]}}} : 13'h0000;

  generate
    for (genvar g = 0; g < 13; g++) begin : g_flag
      if (implemented(g) || g == SUPPLY_IRQ_BIT) begin : g_impl
        flag_edge_latch u_flag (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .set_i(set_vec[g]),
          .hw_clear_i(1'b0),
          .sw_we_i(fl_we[g]),
          .sw_val_i(wr16[g]),
          .flag_o(flags[g]),
          .rise_o(rises[g])
        );
      end else begin : g_none
        assign flags[g] = 1'b0;
        assign rises[g] = 1'b0;
      end
    end
  endgenerate

  // =====================================================
  // next state
  logic pending;
  logic take;
  logic supply_low;

  assign supply_low = st.cmp_sync[1] && st.supply_ctrl[SUPPLY_ON_BIT];
  assign dly_done = st.dly_run && (st.dly == DLY_W'(SUPPLY_IRQ_DELAY_CYC - 1));
  assign pending = |(flags & st.enables);
  assign take = st.global_en && st.group_en && st.group_flag && !stack_full_i;

  always_comb begin
    next_st = st;
    next_st.cmp_sync = {st.cmp_sync[0], supply_below_i};
    next_st.ack = cyc_i && stb_i && !st.ack;
    next_st.push = 1'b0;
    // supply-low settling delay, restarted when the flag rises, cleared when it drops
    if (!supply_low) begin
      next_st.dly_run = 1'b0;
      next_st.dly = '0;
    end else if (!st.supply_ctrl[SUPPLY_LOW_BIT]) begin
      next_st.dly_run = 1'b1;
      next_st.dly = '0;
    end else if (dly_done) begin
      next_st.dly_run = 1'b0;
    end else if (st.dly_run) begin
      next_st.dly = st.dly + 1'b1;
    end
    next_st.supply_ctrl[SUPPLY_LOW_BIT] = supply_low;
    if (hit(OFS_SUPPLY_MONITOR_CONTROL)) begin
      next_st.supply_ctrl = (dat_i[7:0] & SUPPLY_CTRL_WMASK)
                          | (next_st.supply_ctrl & ~SUPPLY_CTRL_WMASK);
    end
    if (cyc_i && stb_i && we_i && !st.ack && adr_i == OFS_TM_ENABLES) begin
      for (int b = 0; b < 13; b++) begin
        if ((b < 8 ? sel_i[0] : sel_i[1]) && (implemented(b) || b == SUPPLY_IRQ_BIT)) begin
          next_st.enables[b] = dat_i[b];
        end
      end
    end
    if (hit(OFS_CORE_CTRL)) begin
      next_st.global_en = dat_i[GLOBAL_EN_BIT];
      next_st.group_en = dat_i[GROUP_EN_BIT];
      next_st.group_flag = dat_i[GROUP_FLAG_BIT];
      next_st.sleep = dat_i[SLEEP_BIT];
    end
    if (pending) begin
      next_st.group_flag = 1'b1;
    end
    unique case (st.core)
      CORE_RUN: begin
        next_st.vreq = 1'b0;
        if (return_from_irq_i) begin
          next_st.global_en = 1'b1;
        end
        if (take) begin
          next_st.core = CORE_VECTOR;
          next_st.vreq = 1'b1;
        end
      end
      CORE_VECTOR: begin
        if (vector_ack_i) begin
          next_st.vreq = 1'b0;
          next_st.global_en = 1'b0;
          next_st.group_flag = 1'b0;
          next_st.push = 1'b1;
          next_st.push_data = pc_i;
          next_st.sleep = 1'b0;
          next_st.core = CORE_SERVICE;
        end
      end
      CORE_SERVICE: begin
        if (return_from_irq_i) begin
          next_st.global_en = 1'b1;
          next_st.core = CORE_RUN;
        end else if (return_plain_i) begin
          next_st.core = CORE_RUN;
        end
      end
    endcase
    // wake on any flag rise, independent of enables
    next_st.wake = st.sleep && (|rises);
    if (next_st.wake) begin
      next_st.sleep = 1'b0;
    end
    // event status, set wins over write-one-to-clear
    if (hit(OFS_IRQ_STATUS)) begin
      next_st.status = st.status & ~dat_i[EV_W-1:0];
    end
    if (|rises[11:0]) next_st.status[EV_TM_BIT] = 1'b1;
    if (rises[SUPPLY_IRQ_BIT]) next_st.status[EV_SUPPLY_BIT] = 1'b1;
    if (next_st.wake) next_st.status[EV_WAKE_BIT] = 1'b1;
    if (st.core == CORE_VECTOR && vector_ack_i) next_st.status[EV_VECTOR_BIT] = 1'b1;
    if (hit(OFS_IRQ_MASK)) begin
      next_st.mask = dat_i[EV_W-1:0];
    end
    next_st.irq = |(next_st.status & next_st.mask);
    // read data
    next_st.rdata = 32'h0000_0000;
    if (cyc_i && stb_i && !we_i && !st.ack) begin
      unique case (adr_i)
        OFS_SUPPLY_MONITOR_CONTROL: next_st.rdata = {24'h000000, st.supply_ctrl};
        OFS_TM_FLAGS: next_st.rdata = {19'h00000, flags};
        OFS_TM_ENABLES: next_st.rdata = {19'h00000, st.enables};
        OFS_CORE_CTRL: next_st.rdata = {27'h0000000, st.sleep, stack_full_i,
                                        st.group_flag, st.group_en, st.global_en};
        OFS_IRQ_STATUS: next_st.rdata = {28'h0000000, st.status};
        OFS_IRQ_MASK: next_st.rdata = {28'h0000000, st.mask};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.core <= CORE_RUN;
      st.supply_ctrl <= SUPPLY_CTRL_RST;
      st.mask <= MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // =====================================================
  // outputs
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign supply_monitor_on_o = st.supply_ctrl[SUPPLY_ON_BIT];
  assign supply_threshold_sel_o = st.supply_ctrl[SUPPLY_SEL_LSB +: SUPPLY_SEL_W];
  assign vector_req_o = st.vreq;
  assign push_pc_o = st.push;
  assign push_pc_data_o = st.push_data;
  assign global_irq_enable_o = st.global_en;
  assign wake_o = st.wake;
  assign irq_o = st.irq;

endmodule : irq_wakeup_supply_monitor

/* File: testbench/irq_wakeup_props.sv */
// checker: bus answer, vector entry, return and wake relations at the block's ports
// assumes it is bound onto the block; one clock domain, reset synchronous
`timescale 1ns/1ps
module irq_wakeup_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  // processor core
  input wire logic stack_full_i,
  input wire logic vector_ack_i,
  input wire logic [11:0] pc_i,
  input wire logic return_from_irq_i,
  input wire logic return_plain_i,
  input wire logic vector_req_o,
  input wire logic push_pc_o,
  input wire logic [11:0] push_pc_data_o,
  input wire logic global_irq_enable_o,
  // supply detector and wake
  input wire logic supply_monitor_on_o,
  input wire logic [2:0] supply_threshold_sel_o,
  input wire logic wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // properties
  a_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer is not one pulse one cycle after request");
  a_vector_gated: assert property ($rose(vector_req_o) |-> $past(global_irq_enable_o && !stack_full_i))
    else $error("vector requested without enable or with full stack");
  a_vector_holds: assert property (vector_req_o && !vector_ack_i |=> vector_req_o)
    else $error("vector request dropped before acceptance");
  a_entry_clears: assert property (vector_req_o && vector_ack_i |=> !global_irq_enable_o)
    else $error("global enable still set after entry");
  a_push_pc: assert property (vector_req_o && vector_ack_i |=> push_pc_o && push_pc_data_o == $past(pc_i))
    else $error("entry did not push the program counter");
  a_push_only_entry: assert property (push_pc_o |-> $past(vector_req_o && vector_ack_i))
    else $error("push without an entry");
  a_return_from_irq_sets: assert property (return_from_irq_i |=> global_irq_enable_o)
    else $error("interrupt return left global enable low");
  a_ret_keeps: assert property (return_plain_i && !global_irq_enable_o && !cyc_i && !$past(cyc_i)
    |=> !global_irq_enable_o)
    else $error("plain return set global enable");
  a_ctrl_by_write: assert property ($changed({supply_monitor_on_o, supply_threshold_sel_o})
    |-> $past(cyc_i && we_i))
    else $error("detector control changed without a write");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
endmodule : irq_wakeup_props

bind irq_wakeup_supply_monitor irq_wakeup_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
  .stack_full_i(stack_full_i), .vector_ack_i(vector_ack_i), .pc_i(pc_i),
  .return_from_irq_i(return_from_irq_i), .return_plain_i(return_plain_i),
  .vector_req_o(vector_req_o), .push_pc_o(push_pc_o), .push_pc_data_o(push_pc_data_o),
  .global_irq_enable_o(global_irq_enable_o), .supply_monitor_on_o(supply_monitor_on_o),
  .supply_threshold_sel_o(supply_threshold_sel_o), .wake_o(wake_o));

/* File: testbench/core_model.sv */
// model of the processor core: accepts a vector after a chosen lag, shows a moving pc
// assumes vector request is a level held until accepted
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // vector handshake
  input wire logic vector_req_i,
  input wire logic [3:0] lag_i,
  output logic vector_ack_o,
  output logic [11:0] pc_o
);
  logic [3:0] cnt;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      vector_ack_o <= 1'b0;
      pc_o <= 12'h000;
    end else begin
      pc_o <= pc_o + 12'h001;
      vector_ack_o <= 1'b0;
      if (vector_req_i && !vector_ack_o) begin
        cnt <= cnt + 4'h1;
        if (cnt == lag_i) begin
          vector_ack_o <= 1'b1;
          cnt <= 4'h0;
        end
      end
    end
  end
endmodule : core_model

/* File: testbench/irq_wakeup_supply_monitor_bench.sv */
// bench: register, timer flag, wake, vector and supply detector checks
// assumes the package offsets and a 100 MHz clock
`timescale 1ns/1ps
module irq_wakeup_supply_monitor_bench;
  import irq_wakeup_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, supply_below_i = 0;
  logic stack_full_i = 0, return_from_irq_i = 0, return_plain_i = 0, pushed = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0, lag = 4'h0;
  logic [31:0] dat_i = 32'h0, q, dat_o;
  logic [2:0] tp = 3'h0, ta = 3'h0, tb = 3'h0, supply_threshold_sel_o;
  logic [11:0] pc_i, push_pc_data_o, pc_at, pc_got;
  logic ack_o, supply_monitor_on_o, vector_req_o, vector_ack_i, push_pc_o;
  logic global_irq_enable_o, wake_o, irq_o;
  int error_cnt = 0, total_checks = 0, wakes = 0, seed = 32'h1309bd7a, mflags, v, i, n;
  always #5 clk_i = ~clk_i;
  irq_wakeup_supply_monitor dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tm_period_match_i(tp), .tm_compare_a_i(ta), .tm_compare_b_i(tb),
    .supply_below_i(supply_below_i), .supply_monitor_on_o(supply_monitor_on_o),
    .supply_threshold_sel_o(supply_threshold_sel_o), .stack_full_i(stack_full_i),
    .vector_ack_i(vector_ack_i), .pc_i(pc_i), .return_from_irq_i(return_from_irq_i),
    .return_plain_i(return_plain_i), .vector_req_o(vector_req_o), .push_pc_o(push_pc_o),
    .push_pc_data_o(push_pc_data_o), .global_irq_enable_o(global_irq_enable_o),
    .wake_o(wake_o), .irq_o(irq_o));
  core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .vector_req_i(vector_req_o), .lag_i(lag),
    .vector_ack_o(vector_ack_i), .pc_o(pc_i));
  // ==========
  // observers
  always @(negedge clk_i) begin
    if (wake_o === 1'b1) wakes++;
    if (vector_req_o === 1'b1 && vector_ack_i === 1'b1) pc_at = pc_i;
    if (push_pc_o === 1'b1) begin
      pc_got = push_pc_data_o;
      pushed = 1'b1;
    end
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic pulse(input logic [2:0] p, input logic [2:0] a, input logic [2:0] b);
    tp <= p;
    ta <= a;
    tb <= b;
    @(posedge clk_i);
    tp <= 3'h0;
    ta <= 3'h0;
    tb <= 3'h0;
    @(posedge clk_i);
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
  // ==========
  // scenarios
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, OFS_SUPPLY_MONITOR_CONTROL, 0);
    chk(q, SUPPLY_CTRL_RST);
    wb(1, 8'h40, 32'hFFFFFFFF);
    wb(0, 8'h40, 0);
    chk(q, 0);
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      v[2:0] = i[2:0];
      wb(1, OFS_SUPPLY_MONITOR_CONTROL, v);
      wb(0, OFS_SUPPLY_MONITOR_CONTROL, 0);
      chk(q, v & 32'h17);
      chk(supply_threshold_sel_o, i);
      chk(supply_monitor_on_o, v[4]);
    end
    pulse(3'h7, 3'h7, 3'h7);
    mflags = 0;
    for (i = 0; i < NUM_TM; i++) mflags |= 3 << (TM_STRIDE * i);
    mflags |= 1 << (TM_STRIDE * ENHANCED_TM + TM_B_BIT);
    wb(0, OFS_TM_FLAGS, 0);
    chk(q, mflags);
    wb(1, OFS_IRQ_MASK, 1);
    chk(irq_o, 1);
    wb(1, OFS_IRQ_STATUS, 1);
    chk(irq_o, 0);
    wb(1, OFS_IRQ_MASK, 0);
    wb(1, OFS_CORE_CTRL, 1 << SLEEP_BIT);
    wb(1, OFS_TM_FLAGS, 0);
    pulse(3'h0, 3'h2, 3'h0);
    wb(0, OFS_TM_FLAGS, 0);
    chk(q, 1 << (TM_STRIDE + TM_A_BIT));
    chk(wakes, 1);
    wb(1, OFS_TM_FLAGS, 1 << TM_STRIDE);
    wb(1, OFS_CORE_CTRL, 1 << SLEEP_BIT);
    pulse(3'h2, 3'h0, 3'h0);
    wb(0, OFS_TM_FLAGS, 0);
    chk(q, 1 << TM_STRIDE);
    chk(wakes, 1);
    wb(1, OFS_TM_FLAGS, 0);
    v = $random(seed);
    lag <= {1'b0, v[2:0]};
    wb(1, OFS_TM_ENABLES, 1);
    pulse(3'h1, 3'h0, 3'h0);
    stack_full_i <= 1'b1;
    wb(1, OFS_CORE_CTRL, 3);
    repeat (20) @(posedge clk_i);
    wb(0, OFS_IRQ_STATUS, 0);
    chk(q[EV_VECTOR_BIT], 0);
    chk(wakes, 2);
    stack_full_i <= 1'b0;
    for (n = 0; n < 40 && !pushed; n++) @(posedge clk_i);
    chk(pc_got, pc_at);
    wb(0, OFS_CORE_CTRL, 0);
    chk(q[GLOBAL_EN_BIT], 0);
    wb(0, OFS_TM_FLAGS, 0);
    chk(q, 1);
    wb(1, OFS_TM_FLAGS, 0);
    wb(1, OFS_CORE_CTRL, 0);
    return_plain_i <= 1'b1;
    @(posedge clk_i);
    return_plain_i <= 1'b0;
    wb(0, OFS_CORE_CTRL, 0);
    chk(q[GLOBAL_EN_BIT], 0);
    return_from_irq_i <= 1'b1;
    @(posedge clk_i);
    return_from_irq_i <= 1'b0;
    wb(0, OFS_CORE_CTRL, 0);
    chk(q[GLOBAL_EN_BIT], 1);
    wb(1, OFS_CORE_CTRL, 1 << SLEEP_BIT);
    wb(1, OFS_SUPPLY_MONITOR_CONTROL, 32'h15);
    supply_below_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(0, OFS_SUPPLY_MONITOR_CONTROL, 0);
    chk(q, 32'h35);
    supply_below_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(0, OFS_SUPPLY_MONITOR_CONTROL, 0);
    chk(q, 32'h15);
    supply_below_i <= 1'b1;
    repeat (1400) @(posedge clk_i);
    wb(0, OFS_TM_FLAGS, 0);
    chk(q[SUPPLY_IRQ_BIT], 0);
    repeat (150) @(posedge clk_i);
    wb(0, OFS_TM_FLAGS, 0);
    chk(q[SUPPLY_IRQ_BIT], 1);
    chk(wakes, 3);
    wb(1, OFS_TM_FLAGS, 0);
    tally_and_finish();
  end
endmodule : irq_wakeup_supply_monitor_bench
